// ==== atsl_pkg.sv ====
// Shared constants for the adaptive threshold stage logic: widths, map, fields, resets.
// Assumes a 16-bit converter result and at most fifteen conversion stages.
package atsl_pkg;

	// Widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int STG_W  = 4;
	localparam int SEL_W  = 4;
	localparam int FAC_W  = 7;

	// Sensitivity levels: (PCT_BASE + PCT_STEP * sel) / 2**PCT_SHIFT, 25 % up to 95.3125 %
	localparam logic [FAC_W-1:0] PCT_BASE  = 7'h10;
	localparam logic [FAC_W-1:0] PCT_STEP  = 7'h03;
	localparam int               PCT_SHIFT = 6;

	// Address regions: ADDR[7:4] is the region, ADDR[3:0] the field
	localparam logic [3:0] RG_GLOBAL    = 4'h0;
	localparam logic [3:0] A_PUSH_DELTA = 4'h0;
	localparam logic [3:0] A_STATUS     = 4'h1;
	localparam logic [3:0] A_MASK       = 4'h2;
	localparam logic [3:0] A_ACTIVE     = 4'h3;

	// Per-stage fields, stage s lives in region s+1
	localparam logic [3:0] F_SENS   = 4'h0;
	localparam logic [3:0] F_PEAK   = 4'h1;
	localparam logic [3:0] F_OFF_LO = 4'h2;
	localparam logic [3:0] F_OFF_HI = 4'h3;
	localparam logic [3:0] F_CLP_LO = 4'h4;
	localparam logic [3:0] F_CLP_HI = 4'h5;
	localparam logic [3:0] F_AMB    = 4'h6;
	localparam logic [3:0] F_TH_HI  = 4'h7;
	localparam logic [3:0] F_TH_LO  = 4'h8;

	// Field positions inside the sensitivity and peak words
	localparam int LO_SEL_LSB = 0;
	localparam int HI_SEL_LSB = 4;

	// Reset values
	localparam logic [DATA_W-1:0] RST_DELTA = 16'h0010;
	localparam logic [7:0]        RST_SENS  = 8'h88;
	localparam logic [7:0]        RST_PEAK  = 8'h88;
	localparam logic [DATA_W-1:0] RST_OFF   = 16'h0000;
	localparam logic [DATA_W-1:0] RST_CLP   = 16'hFFFF;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_MAX  = 16'hFFFF;

endpackage : atsl_pkg

// ==== atsl_pct_scale.sv ====
// Percentage scaler: span times one of sixteen fractions in 3/64 steps, from 16/64 to 61/64.
// Pure combinational; the caller registers the result.
`timescale 1ns/10ps

module atsl_pct_scale
	import atsl_pkg::*;
(
	input  wire logic [DATA_W-1:0] span,
	input  wire logic [SEL_W-1:0]  sel,
	output logic      [DATA_W-1:0] scaled
);

	logic [FAC_W-1:0]        factor;
	logic [DATA_W+FAC_W-1:0] prod;

	// Factor tops out at 61/64 so the result never exceeds the span
	always_comb begin
		factor = PCT_BASE + FAC_W'(FAC_W'(sel) * PCT_STEP);
		prod   = (DATA_W+FAC_W)'(span) * (DATA_W+FAC_W)'(factor);
		scaled = prod[PCT_SHIFT +: DATA_W];
	end

endmodule : atsl_pct_scale

// ==== atsl_top.sv ====
// Adaptive threshold, ambient tracking and activation interrupt for all conversion stages.
// Assumes one converter result per valid cycle, tagged with its stage, synchronous to REF_CLK.
`timescale 1ns/10ps

module atsl_top #(
	parameter int NUM_STAGES = 12,
	parameter int FIFO_LOG2  = 2
) (
	input  wire logic                          REF_CLK,
	input  wire logic                          SYS_RST,
	input  wire logic                          CE,
	input  wire logic [atsl_pkg::ADDR_W-1:0]   ADDR,
	input  wire logic [atsl_pkg::DATA_W-1:0]   WDATA,
	input  wire logic                          WR_EN,
	input  wire logic                          RD_EN,
	output logic      [atsl_pkg::DATA_W-1:0]   RDATA,
	input  wire logic                          CDC_VALID,
	input  wire logic [atsl_pkg::STG_W-1:0]    CDC_STAGE,
	input  wire logic [atsl_pkg::DATA_W-1:0]   CDC_DATA,
	output logic                               IRQ
);
	import atsl_pkg::*;

	localparam int DEPTH = 1 << FIFO_LOG2;
	localparam int SUM_W = DATA_W + FIFO_LOG2;

	// Per-stage state
	logic [7:0]           sens_r    [NUM_STAGES];
	logic [7:0]           peak_r    [NUM_STAGES];
	logic [DATA_W-1:0]    off_lo_r  [NUM_STAGES];
	logic [DATA_W-1:0]    off_hi_r  [NUM_STAGES];
	logic [DATA_W-1:0]    clp_lo_r  [NUM_STAGES];
	logic [DATA_W-1:0]    clp_hi_r  [NUM_STAGES];
	logic [DATA_W-1:0]    amb_r     [NUM_STAGES];
	logic [DATA_W-1:0]    th_hi_r   [NUM_STAGES];
	logic [DATA_W-1:0]    th_lo_r   [NUM_STAGES];
	logic [DATA_W-1:0]    last_r    [NUM_STAGES];
	logic [FIFO_LOG2-1:0] wp_r      [NUM_STAGES];
	logic                 primed_r  [NUM_STAGES];
	logic                 act_r     [NUM_STAGES];
	logic [DATA_W-1:0]    fifo_r    [NUM_STAGES*DEPTH];
	logic [NUM_STAGES-1:0] act_vec;

	// Global state
	logic [DATA_W-1:0]     delta_r,  delta_nxt;
	logic [NUM_STAGES-1:0] mask_r,   mask_nxt;
	logic [NUM_STAGES-1:0] status_r, status_nxt;
	logic [DATA_W-1:0]     rdata_r,  rdata_nxt;
	logic [STG_W-1:0]      last_stg_r;

	// Sample path
	logic                smp;
	logic [STG_W-1:0]    stg;
	logic [DATA_W-1:0]   cur_off_lo, cur_off_hi, cur_clp_lo, cur_clp_hi;
	logic [DATA_W-1:0]   cur_amb, cur_th_hi, cur_th_lo, cur_last;
	logic [7:0]          cur_sens, cur_peak;
	logic                cur_act, cur_primed;
	logic [DATA_W-1:0]   resp_hi, resp_lo, avg_hi, avg_lo, diff;
	logic [DATA_W:0]     sum_hi, sum_lo;
	logic                gate_hi, gate_lo, act_new, evt, push;
	logic [DATA_W-1:0]   new_off_hi, new_off_lo, new_th_hi, new_th_lo;
	logic [DATA_W-1:0]   sc_in  [4];
	logic [SEL_W-1:0]    sc_sel [4];
	logic [DATA_W-1:0]   sc_out [4];

	// Register port decode
	logic [3:0]          region, field;
	logic [STG_W-1:0]    rs;
	logic                stage_hit, rd_status;

	assign stg = CDC_STAGE;
	assign smp = CE && CDC_VALID && (CDC_STAGE < STG_W'(NUM_STAGES));
	assign region = ADDR[7:4];
	assign field  = ADDR[3:0];
	assign rs = STG_W'(region - 4'h1);
	assign stage_hit = (region != RG_GLOBAL) && (rs < STG_W'(NUM_STAGES));
	assign rd_status = RD_EN && (region == RG_GLOBAL) && (field == A_STATUS);

	// Values of the stage being converted
	assign cur_off_lo = off_lo_r[stg];
	assign cur_off_hi = off_hi_r[stg];
	assign cur_clp_lo = clp_lo_r[stg];
	assign cur_clp_hi = clp_hi_r[stg];
	assign cur_amb    = amb_r[stg];
	assign cur_th_hi  = th_hi_r[stg];
	assign cur_th_lo  = th_lo_r[stg];
	assign cur_last   = last_r[stg];
	assign cur_sens   = sens_r[stg];
	assign cur_peak   = peak_r[stg];
	assign cur_act    = act_r[stg];
	assign cur_primed = primed_r[stg];

	// Four scalers: two tracking windows, then two thresholds on the updated offsets
	assign sc_in[0]  = cur_off_hi;
	assign sc_sel[0] = cur_peak[HI_SEL_LSB +: SEL_W];
	assign sc_in[1]  = cur_off_lo;
	assign sc_sel[1] = cur_peak[LO_SEL_LSB +: SEL_W];
	assign sc_in[2]  = new_off_hi;
	assign sc_sel[2] = cur_sens[HI_SEL_LSB +: SEL_W];
	assign sc_in[3]  = new_off_lo;
	assign sc_sel[3] = cur_sens[LO_SEL_LSB +: SEL_W];

	for (genvar k = 0; k < 4; k++) begin : g_scale
		atsl_pct_scale u_scale (
			.span   (sc_in[k]),
			.sel    (sc_sel[k]),
			.scaled (sc_out[k])
		);
	end

	// Peak tracking, clamping, thresholds, activation and slow FIFO gating
	always_comb begin
		resp_hi = (CDC_DATA > cur_amb) ? CDC_DATA - cur_amb : DATA_ZERO;
		resp_lo = (CDC_DATA < cur_amb) ? cur_amb - CDC_DATA : DATA_ZERO;
		// Compare as resp >= offset - window without an underflowing subtract
		gate_hi = (CDC_DATA > cur_amb) &&
			(({1'b0, resp_hi} + {1'b0, sc_out[0]}) >= {1'b0, cur_off_hi});
		gate_lo = (CDC_DATA < cur_amb) &&
			(({1'b0, resp_lo} + {1'b0, sc_out[1]}) >= {1'b0, cur_off_lo});
		sum_hi = {1'b0, cur_off_hi} + {1'b0, resp_hi};
		sum_lo = {1'b0, cur_off_lo} + {1'b0, resp_lo};
		avg_hi = sum_hi[DATA_W:1];
		avg_lo = sum_lo[DATA_W:1];
		// Offsets are responses above or below ambient, so they move with the drift
		new_off_hi = cur_off_hi;
		new_off_lo = cur_off_lo;
		if (gate_hi) begin
			new_off_hi = (avg_hi > cur_clp_hi) ? cur_clp_hi : avg_hi;
		end
		if (gate_lo) begin
			new_off_lo = (avg_lo > cur_clp_lo) ? cur_clp_lo : avg_lo;
		end
		// Saturate so a large offset cannot wrap the threshold around the code range
		sum_hi = {1'b0, cur_amb} + {1'b0, sc_out[2]};
		new_th_hi = sum_hi[DATA_W] ? DATA_MAX : sum_hi[DATA_W-1:0];
		new_th_lo = (cur_amb > sc_out[3]) ? cur_amb - sc_out[3] : DATA_ZERO;
		// Activation judged against the thresholds held from the previous conversion
		act_new = (CDC_DATA > cur_th_hi) || (CDC_DATA < cur_th_lo);
		evt = act_new != cur_act;
		diff = (CDC_DATA >= cur_last) ? CDC_DATA - cur_last : cur_last - CDC_DATA;
		// A touched sensor must not drag the ambient level along
		push = !act_new && (!cur_primed || (diff > delta_r));
	end

	// Per-stage registers
	for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
		logic                 here, wsel;
		logic [7:0]           sens_nxt, peak_nxt;
		logic [DATA_W-1:0]    off_lo_nxt, off_hi_nxt, clp_lo_nxt, clp_hi_nxt;
		logic [DATA_W-1:0]    amb_nxt, th_hi_nxt, th_lo_nxt, last_nxt;
		logic [FIFO_LOG2-1:0] wp_nxt;
		logic                 primed_nxt, act_nxt;
		logic [DATA_W-1:0]    fifo_nxt [DEPTH];
		logic [SUM_W-1:0]     sum;

		assign here = smp && (stg == STG_W'(s));
		assign wsel = WR_EN && stage_hit && (rs == STG_W'(s));
		assign act_vec[s] = act_r[s];

		// Host writes win over hardware so start-up values always land
		always_comb begin
			sens_nxt   = sens_r[s];
			peak_nxt   = peak_r[s];
			off_lo_nxt = off_lo_r[s];
			off_hi_nxt = off_hi_r[s];
			clp_lo_nxt = clp_lo_r[s];
			clp_hi_nxt = clp_hi_r[s];
			th_hi_nxt  = th_hi_r[s];
			th_lo_nxt  = th_lo_r[s];
			last_nxt   = last_r[s];
			wp_nxt     = wp_r[s];
			primed_nxt = primed_r[s];
			act_nxt    = act_r[s];
			for (int k = 0; k < DEPTH; k++) begin
				fifo_nxt[k] = fifo_r[s*DEPTH+k];
			end
			if (here) begin
				off_lo_nxt = new_off_lo;
				off_hi_nxt = new_off_hi;
				th_hi_nxt  = new_th_hi;
				th_lo_nxt  = new_th_lo;
				act_nxt    = act_new;
				if (push) begin
					// First push fills the whole FIFO so ambient starts at the sample
					for (int k = 0; k < DEPTH; k++) begin
						if (!primed_r[s] || (wp_r[s] == FIFO_LOG2'(k))) begin
							fifo_nxt[k] = CDC_DATA;
						end
					end
					wp_nxt     = wp_r[s] + 1'b1;
					primed_nxt = 1'b1;
					last_nxt   = CDC_DATA;
				end
			end
			if (wsel) begin
				case (field)
					F_SENS:   sens_nxt   = WDATA[7:0];
					F_PEAK:   peak_nxt   = WDATA[7:0];
					F_OFF_LO: off_lo_nxt = WDATA;
					F_OFF_HI: off_hi_nxt = WDATA;
					F_CLP_LO: clp_lo_nxt = WDATA;
					F_CLP_HI: clp_hi_nxt = WDATA;
					default:  ;
				endcase
			end
			sum = '0;
			for (int k = 0; k < DEPTH; k++) begin
				sum = sum + SUM_W'(fifo_nxt[k]);
			end
			amb_nxt = sum[FIFO_LOG2 +: DATA_W];
		end

		always_ff @(posedge REF_CLK) begin
			if (SYS_RST) begin
				sens_r[s]   <= RST_SENS;
				peak_r[s]   <= RST_PEAK;
				off_lo_r[s] <= RST_OFF;
				off_hi_r[s] <= RST_OFF;
				clp_lo_r[s] <= RST_CLP;
				clp_hi_r[s] <= RST_CLP;
				amb_r[s]    <= DATA_ZERO;
				th_hi_r[s]  <= DATA_MAX;
				th_lo_r[s]  <= DATA_ZERO;
				last_r[s]   <= DATA_ZERO;
				wp_r[s]     <= '0;
				primed_r[s] <= 1'b0;
				act_r[s]    <= 1'b0;
				for (int k = 0; k < DEPTH; k++) begin
					fifo_r[s*DEPTH+k] <= DATA_ZERO;
				end
			end else if (CE) begin
				sens_r[s]   <= sens_nxt;
				peak_r[s]   <= peak_nxt;
				off_lo_r[s] <= off_lo_nxt;
				off_hi_r[s] <= off_hi_nxt;
				clp_lo_r[s] <= clp_lo_nxt;
				clp_hi_r[s] <= clp_hi_nxt;
				amb_r[s]    <= amb_nxt;
				th_hi_r[s]  <= th_hi_nxt;
				th_lo_r[s]  <= th_lo_nxt;
				last_r[s]   <= last_nxt;
				wp_r[s]     <= wp_nxt;
				primed_r[s] <= primed_nxt;
				act_r[s]    <= act_nxt;
				for (int k = 0; k < DEPTH; k++) begin
					fifo_r[s*DEPTH+k] <= fifo_nxt[k];
				end
			end
		end
	end

	// Global registers, interrupt status and read data
	always_comb begin
		delta_nxt  = delta_r;
		mask_nxt   = mask_r;
		status_nxt = status_r;
		rdata_nxt  = DATA_ZERO;
		if (WR_EN && (region == RG_GLOBAL)) begin
			case (field)
				A_PUSH_DELTA: delta_nxt = WDATA;
				A_MASK:       mask_nxt  = WDATA[NUM_STAGES-1:0];
				default:      ;
			endcase
		end
		if (RD_EN && (region == RG_GLOBAL)) begin
			case (field)
				A_PUSH_DELTA: rdata_nxt = delta_r;
				A_STATUS:     rdata_nxt = DATA_W'(status_r);
				A_MASK:       rdata_nxt = DATA_W'(mask_r);
				A_ACTIVE:     rdata_nxt = DATA_W'(act_vec);
				default:      rdata_nxt = DATA_ZERO;
			endcase
		end else if (RD_EN && stage_hit) begin
			case (field)
				F_SENS:   rdata_nxt = DATA_W'(sens_r[rs]);
				F_PEAK:   rdata_nxt = DATA_W'(peak_r[rs]);
				F_OFF_LO: rdata_nxt = off_lo_r[rs];
				F_OFF_HI: rdata_nxt = off_hi_r[rs];
				F_CLP_LO: rdata_nxt = clp_lo_r[rs];
				F_CLP_HI: rdata_nxt = clp_hi_r[rs];
				F_AMB:    rdata_nxt = amb_r[rs];
				F_TH_HI:  rdata_nxt = th_hi_r[rs];
				F_TH_LO:  rdata_nxt = th_lo_r[rs];
				default:  rdata_nxt = DATA_ZERO;
			endcase
		end
		// Read clears, but an event in the same cycle survives
		if (rd_status) begin
			status_nxt = '0;
		end
		if (smp && evt) begin
			status_nxt = status_nxt | (NUM_STAGES'(1) << stg);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			delta_r    <= RST_DELTA;
			mask_r     <= '0;
			status_r   <= '0;
			rdata_r    <= DATA_ZERO;
			last_stg_r <= '0;
		end else if (CE) begin
			delta_r    <= delta_nxt;
			mask_r     <= mask_nxt;
			status_r   <= status_nxt;
			rdata_r    <= rdata_nxt;
			last_stg_r <= stg;
		end
	end

	assign RDATA = rdata_r;
	assign IRQ   = |(status_r & mask_r);

	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_touch_evt;
		smp && evt;
	endsequence

	sequence s_status_rd;
		CE && rd_status;
	endsequence

	irq_on_event_a: assert property (s_touch_evt ##0 mask_r[stg] |=> IRQ)
		else $error("unmasked activation change did not raise the interrupt");
	set_wins_a: assert property (s_touch_evt ##0 s_status_rd |=> status_r[last_stg_r])
		else $error("activation change lost against a status read");
	status_clear_a: assert property (s_status_rd ##0 !smp |=>
		(status_r == '0) && (RDATA == DATA_W'($past(status_r))))
		else $error("status read did not return and clear the status");
	min_gate_a: assert property (smp && !gate_lo && !WR_EN |=>
		off_lo_r[last_stg_r] == $past(cur_off_lo))
		else $error("low offset moved outside its tracking window");
	max_gate_a: assert property (smp && !gate_hi && !WR_EN |=>
		off_hi_r[last_stg_r] == $past(cur_off_hi))
		else $error("high offset moved outside its tracking window");
	clamp_hold_a: assert property (smp && (gate_hi || gate_lo) && !WR_EN |=>
		(off_hi_r[last_stg_r] <= clp_hi_r[last_stg_r] || !$past(gate_hi)) &&
		(off_lo_r[last_stg_r] <= clp_lo_r[last_stg_r] || !$past(gate_lo)))
		else $error("tracked offset exceeds its clamp");
	offset_track_a: assert property (smp && gate_hi && !WR_EN &&
		({1'b0, resp_hi} > ({1'b0, cur_off_hi} + 17'h00001)) && (cur_off_hi < cur_clp_hi) |=>
		off_hi_r[last_stg_r] > $past(cur_off_hi))
		else $error("high offset did not follow a larger response");
	thresh_recomp_a: assert property (smp && !WR_EN |=>
		(th_hi_r[last_stg_r] >= $past(cur_amb)) && (th_lo_r[last_stg_r] <= $past(cur_amb)))
		else $error("thresholds not referenced to the ambient level");
	push_gate_a: assert property (smp && !push && !WR_EN |=>
		amb_r[last_stg_r] == $past(cur_amb))
		else $error("ambient changed without a slow FIFO push");
	ambient_seed_a: assert property (smp && push && !cur_primed |=>
		amb_r[last_stg_r] == $past(CDC_DATA))
		else $error("first push did not seed the ambient level");

endmodule : atsl_top

// ==== atsl_host_model.sv ====
// Host processor model: register bus master and start-up calibration loader.
// Assumes the block's plain register port, read data standing one cycle after the strobe.
`timescale 1ns/10ps

module atsl_host_model
	import atsl_pkg::*;
(
	input  wire logic              clk,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] wdata,
	output logic                   wr_en,
	output logic                   rd_en,
	input  wire logic [DATA_W-1:0] rdata
);
	// Bus idles with both strobes low
	initial begin
		addr  = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	// One-cycle write, launched just after an edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// One-cycle read; data is only valid in the following cycle
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd

	// Start-up load: clamps first, offsets at 80 % of them, selects written once
	task automatic setup_stage(input logic [3:0] rg, input logic [DATA_W-1:0] clo,
		input logic [DATA_W-1:0] chi, input logic [7:0] sens, input logic [7:0] peak);
		wr({rg, F_CLP_LO}, clo);
		wr({rg, F_CLP_HI}, chi);
		wr({rg, F_OFF_LO}, DATA_W'(clo * 4 / 5));
		wr({rg, F_OFF_HI}, DATA_W'(chi * 4 / 5));
		wr({rg, F_SENS}, {8'h00, sens});
		wr({rg, F_PEAK}, {8'h00, peak});
	endtask : setup_stage

endmodule : atsl_host_model

// ==== tb.sv ====
// Self-checking bench for the adaptive threshold stage logic.
// Assumes the host model owns the register bus while the bench drives the converter side.
`timescale 1ns/10ps

`define CHK(got, exp, msg) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("CHECK FAILED %0t %s", $time, msg); \
		end \
	end

module tb;
	import atsl_pkg::*;

	// Expected stage 0 state after each sample
	typedef struct packed {
		logic [DATA_W-1:0] x, off_hi, off_lo, amb, th_hi, th_lo;
		logic              act;
	} atsl_row_t;

	// Offsets clamp at 0x100 / 0x080, both selects at 25 %, push delta 0x10
	localparam atsl_row_t ROWS [7] = '{
		'{16'h0400, 16'h0100, 16'h0066, 16'h0400, 16'h0040, 16'h0000, 1'b0},
		'{16'h0400, 16'h0100, 16'h0066, 16'h0400, 16'h0440, 16'h03E7, 1'b1},
		'{16'h0410, 16'h0100, 16'h0066, 16'h0400, 16'h0440, 16'h03E7, 1'b0},
		'{16'h0420, 16'h0100, 16'h0066, 16'h0408, 16'h0440, 16'h03E7, 1'b0},
		'{16'h03B8, 16'h0100, 16'h005B, 16'h0408, 16'h0448, 16'h03F2, 1'b1},
		'{16'h0200, 16'h0100, 16'h0080, 16'h0408, 16'h0448, 16'h03E8, 1'b1},
		'{16'h03E0, 16'h0100, 16'h0080, 16'h0408, 16'h0448, 16'h03E8, 1'b1}
	};
	localparam logic [ADDR_W-1:0] RA [10] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12,
		8'h14, 8'h16, 8'h17, 8'h18};
	localparam logic [DATA_W-1:0] RV [10] = '{RST_DELTA, 16'h0000, 16'h0000,
		{8'h00, RST_SENS}, {8'h00, RST_PEAK}, RST_OFF, RST_CLP, DATA_ZERO, DATA_MAX, DATA_ZERO};
	localparam int LIMIT = 2000;

	logic              ref_clk   = 1'b0;
	logic              sys_rst   = 1'b1;
	logic              ce        = 1'b1;
	logic              cdc_valid = 1'b0;
	logic [STG_W-1:0]  cdc_stage = '0;
	logic [DATA_W-1:0] cdc_data  = '0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              wr_en;
	logic              rd_en;
	logic              irq;
	int                mismatches = 0;
	int                cmp_count  = 0;
	int                cycles     = 0;

	// 125 MHz reference clock
	always #4 ref_clk = ~ref_clk;

	atsl_top #(.NUM_STAGES(12), .FIFO_LOG2(2)) atsl_top_inst (
		.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
		.WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata), .CDC_VALID(cdc_valid),
		.CDC_STAGE(cdc_stage), .CDC_DATA(cdc_data), .IRQ(irq));

	atsl_host_model atsl_host_model_inst (.clk(ref_clk), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

	task automatic end_sim();
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	task automatic reset_dut();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
	endtask : reset_dut

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		atsl_host_model_inst.wr(a, v);
	endtask : wr

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input string m);
		logic [DATA_W-1:0] v;
		atsl_host_model_inst.rd(a, v);
		`CHK(v, e, m)
	endtask : rd_chk

	// One converter result; stage state is settled when the task returns
	task automatic sample(input logic [STG_W-1:0] s, input logic [DATA_W-1:0] x);
		@(posedge ref_clk);
		cdc_valid <= 1'b1;
		cdc_stage <= s;
		cdc_data  <= x;
		@(posedge ref_clk);
		cdc_valid <= 1'b0;
		#1;
	endtask : sample

	// Hang guard: a runaway run is counted as a failure
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			end_sim();
		end
	end

	initial begin
		reset_dut();
		atsl_host_model_inst.setup_stage(4'h1, 16'h0080, 16'h0100, 8'h00, 8'h00);
		atsl_host_model_inst.setup_stage(4'h2, 16'h1400, 16'h1400, 8'h00, 8'h00);
		// Ordinary stage 0 traffic, every tracked field read back
		foreach (ROWS[i]) begin
			sample(4'h0, ROWS[i].x);
			rd_chk(8'h13, ROWS[i].off_hi, "high offset");
			rd_chk(8'h12, ROWS[i].off_lo, "low offset");
			rd_chk(8'h16, ROWS[i].amb, "ambient");
			rd_chk(8'h17, ROWS[i].th_hi, "high threshold");
			rd_chk(8'h18, ROWS[i].th_lo, "low threshold");
			rd_chk(8'h03, {15'h0000, ROWS[i].act}, "active flags");
		end
		// Every select level on stage 1 with ambient held at zero
		for (int s = 0; s < 16; s++) begin
			wr(8'h20, {8'h00, 4'(s), 4'(s)});
			sample(4'h1, 16'h0000);
			rd_chk(8'h27, DATA_W'(64 * (16 + 3 * s)), "sensitivity level");
		end
		// Pending event stays hidden until unmasked, then read-clear drops the line
		`CHK(irq, 1'b0, "irq while masked")
		wr(8'h02, 16'h0001);
		#1;
		`CHK(irq, 1'b1, "irq after unmask")
		rd_chk(8'h01, 16'h0001, "status");
		`CHK(irq, 1'b0, "irq after clear")
		// Release of the touch is a new event and feeds the slow FIFO again
		sample(4'h0, 16'h0408);
		`CHK(irq, 1'b1, "irq on release")
		rd_chk(8'h01, 16'h0001, "status on release");
		rd_chk(8'h16, 16'h040A, "ambient after push");
		// Read-only ambient ignores a write; an unmapped field reads zero
		wr(8'h16, 16'h1234);
		rd_chk(8'h16, 16'h040A, "ambient read-only");
		rd_chk(8'h0F, 16'h0000, "unmapped read");
		// Touch and status read in one cycle: the read sees the old word, the set survives
		fork
			sample(4'h0, 16'h0500);
			rd_chk(8'h01, 16'h0000, "status at same-cycle event");
		join
		`CHK(irq, 1'b1, "irq after same-cycle event")
		rd_chk(8'h01, 16'h0001, "set beats read-clear");
		// Clock enable low must freeze host writes and conversions alike
		@(posedge ref_clk);
		ce <= 1'b0;
		wr(8'h00, 16'h0055);
		sample(4'h0, 16'h040A);
		@(posedge ref_clk);
		ce <= 1'b1;
		rd_chk(8'h00, RST_DELTA, "push delta frozen");
		rd_chk(8'h03, 16'h0001, "active flags frozen");
		// A stage number beyond the last stage is dropped without an event
		sample(4'hF, 16'h0000);
		rd_chk(8'h01, 16'h0000, "out-of-range stage");
		// Second reset in mid-run brings back every field read: delta, status, mask and seven stage 0 fields
		reset_dut();
		foreach (RA[i]) rd_chk(RA[i], RV[i], "reset value");
		`CHK(irq, 1'b0, "irq after reset")
		end_sim();
	end

endmodule : tb
